// [rtl/rfm_filter.sv]
// Receive frame match filter: header parser, eight match rows, encapsulation
// check, APB register file and a verdict FIFO toward receive analysis.
// Assumes bytes arrive on pclk from the MAC receive path, first byte marked sof.
// Function
// (R01) Eight rows, each enabled separately.
// (R02) AND inside a row, OR across rows.
// (R03) Masked bits set to one are compared.
// (R04) 32-bit pattern at byte offset from DA.
// (R05) One offset shared by all rows.
// (R06) Eight independent VLAN and MPLS levels.
// (R07) MPLS label, TTL; optional bottom, experimental.
// (R08) VLAN priority, identifier; optional CFI.
// (R09) Permits for type field, SNAP, LLC.
// (R10) No permit set passes every frame.
// (R11) Follow makes port 2 use port 1 setup.
// (R12) Accept only when both checks pass.
// (R13) No row enabled passes the row stage.
module rfm_filter
  import rfm_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         rx_valid,
  input  wire rfm_beat_t    rx_beat,
  output logic              rx_ready,
  output logic              acc_valid,
  input  wire logic         acc_ready,
  output rfm_verdict_t      acc_verdict
);
  logic [31:0]  cfg_q [BANKS][ROWS][WORDS];
  logic [31:0]  ctrl_q, setup_q, npass_q, ndrop_q;
  logic         pready_q, pslverr_q, rx_ready_q;
  logic [31:0]  prdata_q;
  logic         acc_valid_q;
  rfm_verdict_t acc_q;

  // Parsed header of the frame in flight.
  rfm_state_t   st_q;
  logic [15:0]  idx_q;
  logic [1:0]   fc_q;
  logic [23:0]  sh_q;
  logic [47:0]  da_q, sa_q;
  logic [31:0]  pat_q;
  logic         pat_ok_q, port_q;
  logic [15:0]  vl_q [LEVELS];
  logic [31:0]  mp_q [LEVELS];
  logic [3:0]   vl_n_q, mp_n_q;
  logic         eth_q, snap_q, llc_q, eval_q;

  logic         apb_acc, apb_wr, cfg_hit, bad;
  logic         bk, take, push, fifo_ready;
  logic [15:0]  i, off;
  logic [7:0]   b;
  logic [7:0]   rows, en;
  logic [2:0]   perm, encap;
  logic         row_pass, enc_pass;

  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign prdata      = prdata_q;
  assign rx_ready    = rx_ready_q;
  assign acc_valid   = acc_valid_q;
  assign acc_verdict = acc_q;

  // APB decode: the answer comes on the second access cycle.
  assign apb_acc = psel && penable;
  assign apb_wr  = apb_acc && pready_q && pwrite;
  assign cfg_hit = !paddr[11] && (paddr[6:2] < W_LIMIT);
  assign bad     = paddr[11] ? (paddr[10:4] != '0) : !cfg_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_acc && !pready_q;
      pslverr_q <= apb_acc && !pready_q && bad;
      prdata_q  <= 32'h0000_0000;
      if (apb_acc && !pready_q && !pwrite && !bad) begin
        if (!paddr[11]) begin
          prdata_q <= cfg_q[paddr[10]][paddr[9:7]][paddr[6:2]];
        end else begin
          case (paddr)
            A_CTRL:  prdata_q <= ctrl_q;
            A_SETUP: prdata_q <= setup_q;
            A_NPASS: prdata_q <= npass_q;
            A_NDROP: prdata_q <= ndrop_q;
            default: prdata_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Row storage; writes land only on the edge that completes the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < BANKS; k++) begin
        for (int r = 0; r < ROWS; r++) begin
          for (int w = 0; w < WORDS; w++) begin
            cfg_q[k][r][w] <= 32'h0000_0000;
          end
        end
      end
    end else if (apb_wr && cfg_hit) begin
      cfg_q[paddr[10]][paddr[9:7]][paddr[6:2]] <= pwdata;
    end
  end

  // Global control: row enables, follow, offsets and permits per port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= 32'h0000_0000;
      setup_q <= 32'h0000_0000;
    end else if (apb_wr) begin
      if (paddr == A_CTRL) begin
        ctrl_q <= pwdata & 32'h0001_FFFF;
      end
      if (paddr == A_SETUP) begin
        setup_q <= pwdata & 32'h0077_FFFF;
      end
    end
  end

  // Port 2 frames read the port 1 bank while follow is set, so every later
  // change to port 1 shows on port 2 without a copy step.
  assign bk   = port_q && !ctrl_q[B_FOLLOW];                              // [R11]
  assign en   = bk ? ctrl_q[B_EN1 +: ROWS] : ctrl_q[ROWS-1:0];            // [R01]
  assign off  = {8'h00, bk ? setup_q[B_OFF1 +: 8] : setup_q[7:0]};        // [R05]
  assign perm = bk ? setup_q[B_PRM1 +: 3] : setup_q[B_PRM0 +: 3];

  // Per-row compare; a disabled mask compares every bit.
  always_comb begin
    logic [31:0] s, o, v, m;
    logic        hit;
    s    = '0;
    o    = '0;
    v    = '0;
    m    = '0;
    hit  = 1'b0;
    rows = '0;
    for (int r = 0; r < ROWS; r++) begin
      s   = cfg_q[bk][r][W_SEL];
      o   = cfg_q[bk][r][W_OPT];
      hit = 1'b1;
      if (s[B_DA]) begin
        m   = s[B_DAM] ? cfg_q[bk][r][W_DA+2] : 32'hFFFF_FFFF;             // [R03]
        hit = hit && (((da_q[31:0] ^ cfg_q[bk][r][W_DA]) & m) == '0);
        m   = s[B_DAM] ? cfg_q[bk][r][W_DA+3] : 32'hFFFF_FFFF;
        hit = hit && (((da_q[47:32] ^ cfg_q[bk][r][W_DA+1][15:0]) & m[15:0]) == '0);
      end
      if (s[B_SA]) begin
        m   = s[B_SAM] ? cfg_q[bk][r][W_SA+2] : 32'hFFFF_FFFF;             // [R03]
        hit = hit && (((sa_q[31:0] ^ cfg_q[bk][r][W_SA]) & m) == '0);
        m   = s[B_SAM] ? cfg_q[bk][r][W_SA+3] : 32'hFFFF_FFFF;
        hit = hit && (((sa_q[47:32] ^ cfg_q[bk][r][W_SA+1][15:0]) & m[15:0]) == '0);
      end
      if (s[B_PAT]) begin
        m   = s[B_PATM] ? cfg_q[bk][r][W_PAT+1] : 32'hFFFF_FFFF;
        hit = hit && pat_ok_q && (((pat_q ^ cfg_q[bk][r][W_PAT]) & m) == '0); // [R04]
      end
      for (int l = 0; l < LEVELS; l++) begin
        if (s[B_VLS + l]) begin                                           // [R06]
          v   = {16'h0000, vl_q[l]};
          m   = M_VID | (o[B_CFI + l] ? M_CFI : 32'h0000_0000);           // [R08]
          hit = hit && (4'(l) < vl_n_q) && (((v ^ cfg_q[bk][r][W_VL+l]) & m) == '0);
        end
        if (s[B_MPS + l]) begin                                           // [R06]
          m   = M_LBT | (o[B_EXP + l] ? M_EXP : 32'h0000_0000)
                      | (o[B_BOS + l] ? M_BOS : 32'h0000_0000);            // [R07]
          hit = hit && (4'(l) < mp_n_q) && (((mp_q[l] ^ cfg_q[bk][r][W_MP+l]) & m) == '0);
        end
      end
      rows[r] = en[r] && hit;                                             // [R02]
    end
  end

  assign row_pass = (en == '0) || (rows != '0);                           // [R02] [R13]
  assign encap    = {llc_q, snap_q, eth_q};
  assign enc_pass = (perm == '0) || ((perm & encap) != '0);               // [R09] [R10]
  assign push     = eval_q && row_pass && enc_pass;                       // [R12]

  // Byte intake: the stream stalls while a verdict waits for FIFO room.
  assign take = rx_valid && rx_ready_q;
  assign i    = rx_beat.sof ? 16'h0000 : idx_q;
  assign b    = rx_beat.data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ready_q <= 1'b0;
      eval_q     <= 1'b0;
    end else begin
      rx_ready_q <= !(take && rx_beat.eof) && !(eval_q && !fifo_ready && push);
      if (take && rx_beat.eof) begin
        eval_q <= 1'b1;
      end else if (eval_q && (fifo_ready || !push)) begin
        eval_q <= 1'b0;
      end
    end
  end

  // Address and pattern capture by byte position from the first DA byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q    <= 16'h0000;
      da_q     <= '0;
      sa_q     <= '0;
      pat_q    <= 32'h0000_0000;
      pat_ok_q <= 1'b0;
      port_q   <= 1'b0;
    end else if (take) begin
      idx_q <= (i == 16'hFFFF) ? i : i + 16'h0001;
      if (rx_beat.sof) begin
        pat_ok_q <= 1'b0;
        port_q   <= rx_beat.port;
      end
      if (i < I_SA) begin
        da_q <= {da_q[39:0], b};
      end else if (i < I_TYPE) begin
        sa_q <= {sa_q[39:0], b};
      end
      if (i >= off && i <= off + 16'h0003) begin
        pat_q <= {pat_q[23:0], b};                                        // [R04]
        if (i == off + 16'h0003) begin
          pat_ok_q <= 1'b1;
        end
      end
    end
  end

  // Tag walk: VLAN tags and MPLS shims stack up to eight levels each.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= ST_MAC;
      fc_q   <= 2'b00;
      sh_q   <= 24'h000000;
      vl_n_q <= 4'h0;
      mp_n_q <= 4'h0;
      eth_q  <= 1'b0;
      snap_q <= 1'b0;
      llc_q  <= 1'b0;
      for (int l = 0; l < LEVELS; l++) begin
        vl_q[l] <= 16'h0000;
        mp_q[l] <= 32'h0000_0000;
      end
    end else if (take) begin
      sh_q <= {sh_q[15:0], b};
      fc_q <= fc_q + 2'b01;
      if (rx_beat.sof) begin
        st_q   <= ST_MAC;
        vl_n_q <= 4'h0;
        mp_n_q <= 4'h0;
        eth_q  <= 1'b0;
        snap_q <= 1'b0;
        llc_q  <= 1'b0;
      end else begin
        case (st_q)
          ST_MAC: begin
            if (i == I_TYPE - 16'h0001) begin
              st_q <= ST_TYPE;
              fc_q <= 2'b00;
            end
          end
          ST_TYPE: begin
            if (fc_q[0]) begin
              fc_q <= 2'b00;
              if (({sh_q[7:0], b} == T_VLAN || {sh_q[7:0], b} == T_QINQ
                   || {sh_q[7:0], b} == T_QOLD) && vl_n_q < 4'(LEVELS)) begin
                st_q <= ST_VLAN;
              end else if ({sh_q[7:0], b} == T_MPLS || {sh_q[7:0], b} == T_MPLSM) begin
                st_q  <= ST_MPLS;
                eth_q <= 1'b1;
              end else if ({sh_q[7:0], b} >= T_ETH) begin
                st_q  <= ST_REST;
                eth_q <= 1'b1;                                            // [R09]
              end else begin
                st_q <= ST_LLC;
              end
            end
          end
          ST_VLAN: begin
            if (fc_q[0]) begin
              vl_q[vl_n_q[2:0]] <= {sh_q[7:0], b};                        // [R06]
              vl_n_q <= vl_n_q + 4'h1;
              fc_q   <= 2'b00;
              st_q   <= ST_TYPE;
            end
          end
          ST_MPLS: begin
            if (fc_q == 2'b11) begin
              mp_q[mp_n_q[2:0]] <= {sh_q, b};                             // [R06]
              mp_n_q <= mp_n_q + 4'h1;
              if (sh_q[0] || mp_n_q == 4'(LEVELS - 1)) begin
                st_q <= ST_REST;
              end
            end
          end
          ST_LLC: begin
            if (fc_q == 2'b10) begin
              st_q   <= ST_REST;
              snap_q <= ({sh_q[15:0], b} == SNAP_HDR);                    // [R09]
              llc_q  <= ({sh_q[15:0], b} != SNAP_HDR);
            end
          end
          ST_REST: st_q <= ST_REST;
          default: st_q <= ST_MAC;
        endcase
      end
    end
  end

  // Pass and drop tallies for software; a withheld frame only counts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      npass_q <= 32'h0000_0000;
      ndrop_q <= 32'h0000_0000;
    end else if (eval_q) begin
      if (!push) begin
        ndrop_q <= ndrop_q + 32'h0000_0001;                               // [R12]
      end else if (fifo_ready) begin
        npass_q <= npass_q + 32'h0000_0001;
      end
    end
  end

  rfm_verdict_t fifo_out;
  logic         fifo_valid;

  rfm_fifo #(
    .W ($bits(rfm_verdict_t)),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({port_q, rows, encap}),
    .out_valid (fifo_valid),
    .out_ready (!acc_valid_q || acc_ready),
    .out_data  (fifo_out)
  );

  // Output stage keeps the verdict port on flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_valid_q <= 1'b0;
      acc_q       <= '0;
    end else if (!acc_valid_q || acc_ready) begin
      acc_valid_q <= fifo_valid;
      acc_q       <= fifo_out;
    end
  end
endmodule : rfm_filter

// [rtl/rfm_pkg.sv]
// Constants, register map and carrier types of the receive frame match filter.
// Assumes one clock and a byte-wide receive stream from the MAC receive path.
package rfm_pkg;
  localparam int ROWS   = 8;   // Filter rows per port.
  localparam int LEVELS = 8;   // Stacked VLAN and MPLS levels.
  localparam int BANKS  = 2;   // Port 1 and port 2 setups.
  localparam int WORDS  = 32;  // Word slots per row.
  localparam int FIFO_DEPTH = 8;

  // Byte addresses of the global registers.
  localparam logic [11:0] A_CTRL  = 12'h800;
  localparam logic [11:0] A_SETUP = 12'h804;
  localparam logic [11:0] A_NPASS = 12'h808;
  localparam logic [11:0] A_NDROP = 12'h80C;
  localparam logic [11:0] A_GLOB  = 12'h800;  // Bit 11 selects the globals.
  localparam logic [4:0]  W_LIMIT = 5'h1C;    // Row words 28..31 are unmapped.

  // Row word indices.
  localparam int W_SEL = 0;   // Field selects.
  localparam int W_OPT = 1;   // Optional per-level compares.
  localparam int W_DA  = 2;   // 2..3 value, 4..5 mask.
  localparam int W_SA  = 6;   // 6..7 value, 8..9 mask.
  localparam int W_PAT = 10;  // 10 value, 11 mask.
  localparam int W_VL  = 12;  // 12..19 VLAN tags.
  localparam int W_MP  = 20;  // 20..27 MPLS entries.

  // Select word bits.
  localparam int B_DA = 0, B_DAM = 1, B_SA = 2, B_SAM = 3, B_PAT = 4, B_PATM = 5;
  localparam int B_VLS = 8, B_MPS = 16;         // Eight level selects each.
  // Option word bits.
  localparam int B_EXP = 0, B_BOS = 8, B_CFI = 16;

  // Global register fields.
  localparam int B_EN1 = 8, B_FOLLOW = 16, B_OFF1 = 8, B_PRM0 = 16, B_PRM1 = 20;

  // Tag and shim layouts (TCI: pcp, cfi, vid; shim: label, exp, bos, ttl).
  localparam logic [31:0] M_VID = 32'h0000_EFFF, M_CFI = 32'h0000_1000;
  localparam logic [31:0] M_LBT = 32'hFFFF_F0FF, M_EXP = 32'h0000_0E00;
  localparam logic [31:0] M_BOS = 32'h0000_0100;
  localparam int B_SHIM_BOS = 8;

  // Encapsulation codes.
  localparam logic [15:0] T_VLAN = 16'h8100, T_QINQ = 16'h88A8, T_QOLD = 16'h9100;
  localparam logic [15:0] T_MPLS = 16'h8847, T_MPLSM = 16'h8848, T_ETH = 16'h0600;
  localparam logic [23:0] SNAP_HDR = 24'hAAAA03;
  localparam logic [15:0] I_SA = 16'h0006, I_TYPE = 16'h000C;

  typedef enum logic [5:0] {
    ST_MAC  = 6'b000001,
    ST_TYPE = 6'b000010,
    ST_VLAN = 6'b000100,
    ST_MPLS = 6'b001000,
    ST_LLC  = 6'b010000,
    ST_REST = 6'b100000
  } rfm_state_t;

  typedef struct packed {
    logic       sof;
    logic       eof;
    logic       port;
    logic [7:0] data;
  } rfm_beat_t;

  typedef struct packed {
    logic       port;
    logic [7:0] rows;
    logic [2:0] encap;  // Bit 0 type field, 1 SNAP, 2 LLC.
  } rfm_verdict_t;
endpackage : rfm_pkg

// [rtl/rfm_fifo.sv]
// Verdict FIFO with valid and ready on both sides.
// Assumes one clock; full and empty are registered flags.
module rfm_fifo #(
  parameter int W = 12,
  parameter int D = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0]   cnt_q, cnt_d;
  logic          full_q, nempty_q, push, pop;

  assign push      = in_valid && !full_q;
  assign pop       = out_ready && nempty_q;
  assign in_ready  = !full_q;
  assign out_valid = nempty_q;
  assign out_data  = mem[rd_q];
  assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  // Storage needs no reset; only valid slots are ever read out.
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and flags; full holds off the writer until a slot drains.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q     <= '0;
      rd_q     <= '0;
      cnt_q    <= '0;
      full_q   <= 1'b0;
      nempty_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q    <= cnt_d;
      full_q   <= (cnt_d == (AW+1)'(D));
      nempty_q <= (cnt_d != '0);
    end
  end
endmodule : rfm_fifo

// [tb/rfm_filter_assertions.sv]
// Port checks for the receive frame match filter.
// Assumes one clock; enables and permits are shadowed from APB writes.
module rfm_filter_chk
  import rfm_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         rx_valid,
  input wire rfm_beat_t    rx_beat,
  input wire logic         rx_ready,
  input wire logic         acc_valid,
  input wire logic         acc_ready,
  input wire rfm_verdict_t acc_verdict
);
  logic [16:0] ctrl_q;
  logic [6:0]  prm_q;
  logic [7:0]  en_e;
  logic [2:0]  pm_e;
  logic        wr_ok, bad_adr, p2;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Register shadows; updated only at the edge where the write lands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      prm_q  <= '0;
    end else if (wr_ok) begin
      if (paddr == A_CTRL) ctrl_q <= pwdata[16:0];
      if (paddr == A_SETUP) prm_q <= pwdata[22:16];
    end
  end

  // Port 2 uses the port 1 setup while follow is set.
  assign wr_ok   = psel && penable && pready && pwrite;
  assign p2      = acc_verdict.port && !ctrl_q[B_FOLLOW];
  assign en_e    = p2 ? ctrl_q[15:8] : ctrl_q[7:0];
  assign pm_e    = p2 ? prm_q[6:4] : prm_q[2:0];
  assign bad_adr = paddr[11] ? (paddr > A_NDROP + 12'h003) : (paddr[6:2] >= W_LIMIT);

  chk_apb_wait: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  chk_prdata_idle: assert property (!pready |-> prdata == '0)
    else $error("prdata not zero outside answer");
  chk_apb_err: assert property (psel && penable && pready |-> pslverr == bad_adr)
    else $error("pslverr does not match address map");
  chk_rx_gap: assert property (rx_valid && rx_ready && rx_beat.eof |=> !rx_ready)
    else $error("rx_ready high right after eof");
  chk_verdict_hold: assert property (acc_valid && !acc_ready |=> acc_valid && $stable(acc_verdict))
    else $error("verdict changed while stalled");
  chk_rows_enabled: assert property (acc_valid |-> (acc_verdict.rows & ~en_e) == '0)
    else $error("verdict names a disabled row");
  chk_rows_any: assert property (acc_valid && en_e != '0 |-> acc_verdict.rows != '0)
    else $error("frame passed without a matching row");
  chk_permit_ok: assert property (acc_valid && pm_e != '0 |-> (acc_verdict.encap & pm_e) != '0)
    else $error("frame passed with unpermitted encapsulation");

  cov_row_hit: cover property (acc_valid && acc_verdict.rows != '0);
  cov_apb_err: cover property (pready && pslverr);
  cov_full: cover property (acc_valid && !acc_ready && !rx_ready [*4]);
endmodule : rfm_filter_chk

bind rfm_filter rfm_filter_chk rfm_filter_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_valid(rx_valid), .rx_beat(rx_beat), .rx_ready(rx_ready), .acc_valid(acc_valid),
  .acc_ready(acc_ready), .acc_verdict(acc_verdict)
);

// [tb/rfm_mac_model.sv]
// Model of the MAC receive path feeding the filter one byte a beat.
// Assumes the bench fills frm_q and calls send just after a rising edge.
module rfm_mac_model
  import rfm_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic rx_ready,
  output logic      rx_valid,
  output rfm_beat_t rx_beat
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] frm_q[$];

  initial begin
    rx_valid = 1'b0;
    rx_beat  = '0;
  end

  // Each beat is held until taken; ok drops if the filter stalls too long.
  task automatic send(input logic pt, output logic ok);
    int n;
    int k;
    n  = frm_q.size();
    ok = 1'b1;
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_beat  <= '{sof: (i == 0), eof: (i == n - 1), port: pt, data: frm_q[i]};
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (rx_ready !== 1'b1 && k < 40);
      if (k >= 40) ok = 1'b0;
    end
    // Released data shows the inverse so stale bytes cannot match by luck.
    rx_valid     <= 1'b0;
    rx_beat.data <= ~frm_q[n-1];
  endtask : send
endmodule : rfm_mac_model

// [tb/tb_top.sv]
// Self-checking bench for the receive frame match filter.
// Assumes the MAC model at the stream input and an APB master task.
module tb_top
  import rfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic rx_valid, rx_ready, acc_valid, acc_ready, ok;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  rfm_beat_t    rx_beat;
  rfm_verdict_t acc_verdict;
  int miscompares = 0;
  int num_checks = 0;

  rfm_filter rfm_filter_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_beat(rx_beat), .rx_ready(rx_ready), .acc_valid(acc_valid),
    .acc_ready(acc_ready), .acc_verdict(acc_verdict));
  rfm_mac_model rfm_mac_model_inst (.pclk(pclk), .presetn(presetn),
    .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_beat(rx_beat));

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One APB transfer; the request stands until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
    if (pready !== 1'b1) begin
      miscompares++;
      test_done();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic w(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : w

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, '0, q, e);
    check("prdata", q, exp);
    check("pslverr", {31'h0, e}, {31'h0, experr});
  endtask : rd

  function automatic logic [11:0] ra(input int b, input int r, input int wd);
    return 12'(b * 1024 + r * 128 + wd * 4);
  endfunction : ra

  task automatic p16(input logic [15:0] v);
    rfm_mac_model_inst.frm_q.push_back(v[15:8]);
    rfm_mac_model_inst.frm_q.push_back(v[7:0]);
  endtask : p16

  task automatic p32(input logic [31:0] v);
    p16(v[31:16]);
    p16(v[15:0]);
  endtask : p32

  // Header: destination first, then a fixed source 0A0B0C0D0E0F.
  task automatic hdr(input logic [47:0] da);
    rfm_mac_model_inst.frm_q.delete();
    p16(da[47:32]); p32(da[31:0]); p16(16'h0A0B); p32(32'h0C0D_0E0F);
  endtask : hdr

  task automatic tail(input logic [15:0] ty, input logic [31:0] pl);
    p16(ty); p32(pl); p32(32'h0506_0708);
  endtask : tail

  task automatic ef(input logic [47:0] da);
    hdr(da); tail(16'h0800, 32'h0102_0304);
  endtask : ef

  task automatic tx(input logic pt);
    rfm_mac_model_inst.send(pt, ok);
    check("rx_taken", {31'h0, ok}, 32'h1);
    if (!ok) test_done();
  endtask : tx

  // Sends the queued frame and judges the verdict that should follow it.
  task automatic fr(input logic pt, input logic pass, input logic [7:0] rows,
                    input logic [2:0] enc);
    tx(pt);
    for (int k = 0; k < 12 && acc_valid !== 1'b1; k++) @(posedge pclk);
    check("acc_valid", {31'h0, acc_valid}, {31'h0, pass});
    if (pass) check("verdict", {20'h0, acc_verdict}, {20'h0, pt, rows, enc});
  endtask : fr

  task automatic t_apb();
    w(ra(0, 5, W_DA), 32'h1357_9BDF);
    rd(ra(0, 5, W_DA), 32'h1357_9BDF, 1'b0);
    rd(ra(0, 5, 28), 32'h0, 1'b1);
    rd(12'h810, 32'h0, 1'b1);
    $display("t_apb done");
  endtask : t_apb

  task automatic t_rows();
    w(ra(0, 3, W_SEL), 32'h3);
    w(ra(0, 3, W_DA), 32'h3456_789A); w(ra(0, 3, W_DA + 1), 32'h12);
    w(ra(0, 3, W_DA + 2), 32'h00FF_FFFF); w(ra(0, 3, W_DA + 3), 32'hFF);
    w(A_CTRL, 32'h08);
    ef(48'hAB12_CD56_789A); fr(0, 1, 8'h08, 3'h1);
    ef(48'h0013_3456_789A); fr(0, 0, 0, 0);
    w(A_SETUP, 32'h7); w(ra(0, 0, W_SEL), 32'h10); w(ra(0, 0, W_PAT), 32'h0B0C_0D0E);
    w(A_CTRL, 32'h09);
    ef(48'hAB12_CD56_789A); fr(0, 1, 8'h09, 3'h1);
    ef(48'h0013_3456_789A); fr(0, 1, 8'h01, 3'h1);
    w(A_SETUP, 32'h8);
    ef(48'hAB12_CD56_789A); fr(0, 1, 8'h08, 3'h1);
    $display("t_rows done");
  endtask : t_rows

  task automatic t_tags();
    w(ra(0, 1, W_SEL), 32'h300); w(ra(0, 1, W_VL), 32'h6123); w(ra(0, 1, W_VL + 1), 32'h2456);
    w(A_CTRL, 32'h02);
    for (int i = 0; i < 2; i++) begin
      hdr(48'h1); p16(T_VLAN); p16(16'h7123); p16(T_VLAN); p16(16'h2456);
      tail(16'h0800, 32'h0102_0304);
      fr(0, (i == 0), 8'h02, 3'h1);
      w(ra(0, 1, W_OPT), 32'h0001_0000);
    end
    w(ra(0, 2, W_SEL), 32'h0001_0000); w(ra(0, 2, W_MP), 32'h1234_5B40);
    w(A_CTRL, 32'h04);
    for (int i = 0; i < 2; i++) begin
      hdr(48'h1); p16(T_MPLS); p32(32'h1234_5140); p32(32'h0102_0304);
      fr(0, (i == 0), 8'h04, 3'h1);
      w(ra(0, 2, W_OPT), 32'h1);
    end
    $display("t_tags done");
  endtask : t_tags

  // Each permit alone, then none, against three kinds of frame; no rows on.
  task automatic t_encap();
    logic [31:0] pl[3];
    pl = '{32'h0102_0304, 32'hAAAA_0300, 32'h4242_0300};
    w(A_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      w(A_SETUP, (i < 3) ? 32'(1) << (16 + i) : 32'h0);
      for (int j = 0; j < 3; j++) begin
        hdr(48'h1); tail((j == 0) ? 16'h0800 : 16'h0010, pl[j]);
        fr(0, (i == j || i == 3), 8'h00, 3'(1 << j));
      end
    end
    $display("t_encap done");
  endtask : t_encap

  task automatic t_follow();
    w(A_CTRL, 32'h0001_0008);
    ef(48'hAB12_CD56_789A); fr(1, 1, 8'h08, 3'h1);
    ef(48'h0013_3456_789A); fr(1, 0, 0, 0);
    w(ra(0, 3, W_DA + 1), 32'h13);
    ef(48'h0013_3456_789A); fr(1, 1, 8'h08, 3'h1);
    $display("t_follow done");
  endtask : t_follow

  // Downstream stalls until the input refuses, then drains to empty.
  task automatic t_fifo();
    int n;
    int m;
    w(A_CTRL, 32'h0);
    acc_ready <= 1'b0;
    n = 0;
    do begin
      ef(48'h1);
      tx(0);
      n++;
      repeat (6) @(posedge pclk);
    end while (rx_ready === 1'b1 && n < 14);
    check("fill_ge", {31'h0, n >= FIFO_DEPTH + 1}, 32'h1);
    acc_ready <= 1'b1;
    m = 0;
    for (int k = 0; k < 60; k++) begin
      @(posedge pclk);
      if (acc_valid === 1'b1) m++;
    end
    check("drained", m, n);
    check("rx_ready", {31'h0, rx_ready}, 32'h1);
    $display("t_fifo done");
  endtask : t_fifo

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; acc_ready = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_apb(); t_rows(); t_tags(); t_encap(); t_follow(); t_fifo();
    test_done();
  end
endmodule : tb_top
